// ===== bench/agf_top_tb.sv
// Purpose: Self-checking bench for converter gain scaling and result formatting
// Assumes: Register strobes and sample strobes driven on rising edges
// Notes:   Expected bytes worked out by hand from gain and justify settings
`timescale 1ns/1ps
module agf_top_tb;
  import agf_pkg::*;

  logic        ref_clk_i;
  logic        rst_n_i;
  logic [7:0]  reg_addr_i;
  logic [7:0]  reg_wdata_i;
  logic        reg_wr_i;
  logic        reg_rd_i;
  logic [7:0]  reg_rdata_o;
  logic        reg_hit_o;
  logic        raw_valid_i;
  logic [11:0] raw_sample_i;
  logic        conv_done_o;
  int          miscompares;
  int          n_tests;

  agf_top dut (
    .ref_clk_i    (ref_clk_i),
    .rst_n_i      (rst_n_i),
    .reg_addr_i   (reg_addr_i),
    .reg_wdata_i  (reg_wdata_i),
    .reg_wr_i     (reg_wr_i),
    .reg_rd_i     (reg_rd_i),
    .reg_rdata_o  (reg_rdata_o),
    .reg_hit_o    (reg_hit_o),
    .raw_valid_i  (raw_valid_i),
    .raw_sample_i (raw_sample_i),
    .conv_done_o  (conv_done_o)
  );

  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_byte

  task automatic cmp_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_bit

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i    <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp, input logic hit);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i   <= 1'b0;
    #1;
    cmp_byte(reg_rdata_o, exp);
    cmp_bit(reg_hit_o, hit);
  endtask : rd_reg

  // Back-to-back samples, then latency, pulse width and both bytes
  task automatic run(input int n, input logic [11:0] v, input logic [7:0] eh, input logic [7:0] el);
    int k;
    int lat;
    lat = 0;
    for (k = 0; k < n; k++) begin
      @(posedge ref_clk_i);
      raw_valid_i  <= 1'b1;
      raw_sample_i <= v;
    end
    @(posedge ref_clk_i);
    raw_valid_i <= 1'b0;
    for (k = 1; k <= 8 && lat == 0; k++) begin
      @(posedge ref_clk_i);
      #1;
      if (conv_done_o === 1'b1) lat = k;
    end
    cmp_byte(8'(lat), 8'h02);
    @(posedge ref_clk_i);
    #1;
    cmp_bit(conv_done_o, 1'b0);
    rd_reg(AGF_ADDR_RESULT_HIGH, eh, 1'b1);
    rd_reg(AGF_ADDR_RESULT_LOW, el, 1'b1);
  endtask : run

  task automatic close_out;
    $display("checks=%0d mismatches=%0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out

  initial begin
    #100000;
    miscompares++;
    close_out();
  end

  initial begin
    int         r;
    int         cnt[3];
    logic [7:0] hb[3];
    logic [7:0] lb[3];
    cnt = '{4, 8, 16};
    hb  = '{8'h1F, 8'h3F, 8'hFF};
    lb  = '{8'hFC, 8'hF8, 8'hF0};
    miscompares  = 0;
    n_tests      = 0;
    rst_n_i      = 1'b0;
    reg_addr_i   = 8'h00;
    reg_wdata_i  = 8'h00;
    reg_wr_i     = 1'b0;
    reg_rd_i     = 1'b0;
    raw_valid_i  = 1'b0;
    raw_sample_i = 12'h000;
    repeat (6) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    // Reset values and an unmapped address
    rd_reg(AGF_ADDR_GAIN_HIGH, 8'hFC, 1'b1);
    rd_reg(AGF_ADDR_GAIN_LOW, 8'h00, 1'b1);
    rd_reg(AGF_ADDR_GAIN_ADD, 8'h01, 1'b1);
    rd_reg(AGF_ADDR_RESULT_HIGH, 8'h00, 1'b1);
    rd_reg(AGF_ADDR_RESULT_LOW, 8'h00, 1'b1);
    rd_reg(8'h00, 8'h00, 1'b0);
    // Unity default gain, right justified single
    run(1, 12'hABC, 8'h0A, 8'hBC);
    // Half gain
    wr_reg(AGF_ADDR_GAIN_HIGH, 8'h7C);
    run(1, 12'hFFE, 8'h07, 8'hFF);
    // Full gain word, low nibble cleared, offset bit off then on
    wr_reg(AGF_ADDR_GAIN_HIGH, 8'hFF);
    wr_reg(AGF_ADDR_GAIN_LOW, 8'hFF);
    wr_reg(AGF_ADDR_GAIN_ADD, 8'h00);
    rd_reg(AGF_ADDR_GAIN_LOW, 8'hF0, 1'b1);
    run(1, 12'hFFF, 8'h0F, 8'hFE);
    wr_reg(AGF_ADDR_GAIN_ADD, 8'h01);
    run(1, 12'hFFF, 8'h0F, 8'hFF);
    // Back to unity, then accumulation depths four, eight and sixteen
    wr_reg(AGF_ADDR_GAIN_HIGH, 8'hFC);
    wr_reg(AGF_ADDR_GAIN_LOW, 8'h00);
    for (r = 1; r <= 3; r++) begin
      wr_reg(AGF_ADDR_FORMAT, 8'(r));
      run(cnt[r-1], 12'hFFF, hb[r-1], lb[r-1]);
    end
    // Left justified single
    wr_reg(AGF_ADDR_FORMAT, 8'h04);
    run(1, 12'hABC, 8'hAB, 8'hC0);
    // Result high byte is writable
    wr_reg(AGF_ADDR_RESULT_HIGH, 8'h55);
    rd_reg(AGF_ADDR_RESULT_HIGH, 8'h55, 1'b1);
    close_out();
  end

endmodule : agf_top_tb

// ===== design/agf_formatter.sv
// Purpose: Accumulates scaled samples and justifies the result
// Assumes: Repeat and justify settings steady during a sequence
// Notes:   Both result bytes load in the same cycle
`timescale 1ns/1ps
module agf_formatter
  import agf_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       rst_n_i,
  // Settings
  input  wire logic [1:0] repeat_count_select_i,
  input  wire logic       left_justify_select_i,
  // Sample in
  agf_res_if.dst          res,
  // Result out
  output logic            done_o,
  output logic [7:0]      result_high_o,
  output logic [7:0]      result_low_o
);

  typedef struct packed {
    logic        done;
    logic [15:0] acc;
    logic [3:0]  count;
    logic [7:0]  high;
    logic [7:0]  low;
  } agf_fmt_state_t;

  agf_fmt_state_t state;
  agf_fmt_state_t next_state;
  logic [3:0]     last_idx;
  logic [15:0]    sum;

  always_comb begin
    next_state      = state;
    next_state.done = 1'b0;
    case (agf_rpt_t'(repeat_count_select_i))
      AGF_RPT_1:  last_idx = 4'h0;
      AGF_RPT_4:  last_idx = 4'h3;
      AGF_RPT_8:  last_idx = 4'h7;
      AGF_RPT_16: last_idx = 4'hF;
      default:    last_idx = 4'h0;
    endcase
    sum = (state.count == 4'h0) ? {4'h0, res.sample} : state.acc + {4'h0, res.sample};
    if (res.valid) begin
      next_state.acc = sum;
      if (state.count == last_idx) begin
        next_state.count = 4'h0;
        next_state.done  = 1'b1;
        if (left_justify_select_i) begin
          next_state.high = sum[11:4]; // RULE8
          next_state.low  = {sum[3:0], 4'h0}; // RULE11
        end else begin
          case (agf_rpt_t'(repeat_count_select_i))
            AGF_RPT_1:  next_state.high = {4'h0, sum[11:8]}; // RULE4
            AGF_RPT_4:  next_state.high = {3'h0, sum[13:9]}; // RULE5
            AGF_RPT_8:  next_state.high = {2'h0, sum[14:9]}; // RULE6
            AGF_RPT_16: next_state.high = sum[15:8]; // RULE7
            default:    next_state.high = sum[15:8];
          endcase
          next_state.low  = sum[7:0]; // RULE10
        end
      end else begin
        next_state.count = state.count + 4'h1;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      state <= '0;
    end else begin
      state <= next_state; // RULE12
    end
  end

  assign done_o        = state.done;
  assign result_high_o = state.high;
  assign result_low_o  = state.low;

  right_single_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (done_o && !$past(left_justify_select_i) && $past(repeat_count_select_i) == 2'b00)
    |-> result_high_o[7:4] == 4'h0)
    else $error("single result high nibble not zero"); // RULE4
  right_four_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (done_o && !$past(left_justify_select_i) && $past(repeat_count_select_i) == 2'b01)
    |-> (result_high_o[7:5] == 3'h0 && result_high_o[4:0] == state.acc[13:9]))
    else $error("four sum high bits not zero"); // RULE5
  right_eight_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (done_o && !$past(left_justify_select_i) && $past(repeat_count_select_i) == 2'b10)
    |-> (result_high_o[7:6] == 2'h0 && result_high_o[5:0] == state.acc[14:9]))
    else $error("eight sum high bits not zero"); // RULE6
  right_sixteen_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (done_o && !$past(left_justify_select_i) && $past(repeat_count_select_i) == 2'b11)
    |-> {result_high_o, result_low_o} == state.acc)
    else $error("sixteen sum bytes wrong"); // RULE7 RULE10
  left_low_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (done_o && $past(left_justify_select_i)) |-> result_low_o[3:0] == 4'h0)
    else $error("left justified low nibble not zero"); // RULE11
  bytes_together_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (!done_o && !$past(res.valid, 1)) |-> ($stable(result_high_o) && $stable(result_low_o)))
    else $error("result byte changed outside completion"); // RULE12

endmodule : agf_formatter

// ===== design/agf_pkg.sv
// Purpose: Shared constants and types for converter gain and result formatting
// Assumes: Byte-wide special-function-register bus on the system clock
// Notes:   Offsets without a printed address are local choices
package agf_pkg;

  // Register addresses
  localparam logic [7:0] AGF_ADDR_RESULT_LOW  = 8'hBD;
  localparam logic [7:0] AGF_ADDR_RESULT_HIGH = 8'hBE;
  localparam logic [7:0] AGF_ADDR_GAIN_HIGH   = 8'hB4;
  localparam logic [7:0] AGF_ADDR_GAIN_LOW    = 8'hB5;
  localparam logic [7:0] AGF_ADDR_GAIN_ADD    = 8'hB6;
  localparam logic [7:0] AGF_ADDR_FORMAT      = 8'hB7;

  // Reset values
  localparam logic [7:0] AGF_RST_GAIN_HIGH   = 8'hFC;
  localparam logic [7:0] AGF_RST_GAIN_LOW    = 8'h00;
  localparam logic       AGF_RST_GAIN_ADD    = 1'b1;
  localparam logic [7:0] AGF_RST_RESULT      = 8'h00;

  // Field positions
  localparam int AGF_GAIN_ADD_BIT  = 0;
  localparam int AGF_LJST_BIT      = 2;
  localparam int AGF_RPT_LSB       = 0;

  // Arithmetic widths
  localparam int AGF_SAMPLE_W  = 12;
  localparam int AGF_GAIN_W    = 12;
  localparam int AGF_ACC_W     = 16;
  localparam int AGF_GAIN_FRAC = 12;
  localparam int AGF_ADD_SHIFT = 6;

  // Repeat counts
  typedef enum logic [1:0] {
    AGF_RPT_1 = 2'b00,
    AGF_RPT_4 = 2'b01,
    AGF_RPT_8 = 2'b10,
    AGF_RPT_16 = 2'b11
  } agf_rpt_t;

endpackage : agf_pkg

// ===== design/agf_res_if.sv
// Purpose: Carries a finished scaled sample from scaler to formatter
// Assumes: Single clock domain
// Notes:   Valid is high for one cycle per sample
`timescale 1ns/1ps
interface agf_res_if;
  logic        valid;
  logic [11:0] sample;
  modport src (output valid, output sample);
  modport dst (input valid, input sample);
endinterface : agf_res_if

// ===== design/agf_scaler.sv
// Purpose: Multiplies a raw sample by the programmed gain
// Assumes: Gain word and offset bit are stable around a sample strobe
// Notes:   One cycle of latency, result saturates at full scale
`timescale 1ns/1ps
module agf_scaler
  import agf_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  // Gain setting
  input  wire logic [11:0] gain_word_i,
  input  wire logic        gain_offset_add_i,
  // Sample in
  input  wire logic        raw_valid_i,
  input  wire logic [11:0] raw_sample_i,
  // Sample out
  agf_res_if.src           res
);

  typedef struct packed {
    logic        valid;
    logic [11:0] sample;
  } agf_scl_state_t;

  agf_scl_state_t state;
  agf_scl_state_t next_state;
  logic [24:0]    product;
  logic [12:0]    coeff;
  logic [12:0]    scaled;

  always_comb begin
    next_state = state;
    coeff      = {1'b0, gain_word_i} + (gain_offset_add_i ? 13'h0040 : 13'h0000); // RULE2
    product    = {13'h0000, raw_sample_i} * {12'h000, coeff};
    scaled     = product[24:12]; // RULE2
    next_state.valid = raw_valid_i;
    if (raw_valid_i) begin
      next_state.sample = scaled[12] ? 12'hFFF : scaled[11:0];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign res.valid  = state.valid;
  assign res.sample = state.sample;

  unity_gain_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (raw_valid_i && gain_word_i == 12'hFC0 && gain_offset_add_i) |=> (res.sample == $past(raw_sample_i)))
    else $error("unity gain altered sample"); // RULE2

endmodule : agf_scaler

// ===== design/agf_top.sv
// Purpose: Converter gain scaling and result formatting with register access
// Assumes: Byte register bus with one-cycle write and read strobes
// Notes:   Reads answer one cycle after the strobe
//
// Summary of operation
// RULE1 - Gain word is high byte plus low[7:4]
// RULE2 - Gain equals word/4096 plus optional 1/64
// RULE3 - Reset gain FC, 00, offset bit set
// RULE4 - Right justify single: high holds bits 11:8
// RULE5 - Right justify four: high holds bits 13:9
// RULE6 - Right justify eight: high holds bits 14:9
// RULE7 - Right justify sixteen: high holds bits 15:8
// RULE8 - Left justify: high holds result bits 11:4
// RULE9 - Software pairs left justify with single only
// RULE10 - Right justify: low holds lower eight bits
// RULE11 - Left justify: low holds bits 3:0 then zeros
// RULE12 - Both result bytes update in one cycle
`timescale 1ns/1ps
module agf_top
  import agf_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       rst_n_i,
  // Register bus
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic [7:0]      reg_rdata_o,
  output logic            reg_hit_o,
  // Converter samples
  input  wire logic       raw_valid_i,
  input  wire logic [11:0] raw_sample_i,
  // Status
  output logic            conv_done_o
);

  typedef struct packed {
    logic [7:0] gain_high;
    logic [7:0] gain_low;
    logic       gain_offset_add;
    logic       left_justify_select;
    logic [1:0] repeat_count_select;
    logic [7:0] result_high;
    logic [7:0] result_low;
    logic [7:0] rdata;
    logic       hit;
    logic       done;
  } agf_top_state_t;

  agf_top_state_t state;
  agf_top_state_t next_state;
  agf_res_if      res_bus ();
  logic           fmt_done;
  logic [7:0]     fmt_high;
  logic [7:0]     fmt_low;
  logic [11:0]    gain_word;

  assign gain_word = {state.gain_high, state.gain_low[7:4]}; // RULE1

  agf_scaler u_scaler (
    .ref_clk_i         (ref_clk_i),
    .rst_n_i           (rst_n_i),
    .gain_word_i       (gain_word),
    .gain_offset_add_i (state.gain_offset_add),
    .raw_valid_i       (raw_valid_i),
    .raw_sample_i      (raw_sample_i),
    .res               (res_bus.src)
  );

  // Software must keep repeat at single when left justified
  agf_formatter u_formatter (
    .ref_clk_i             (ref_clk_i),
    .rst_n_i               (rst_n_i),
    .repeat_count_select_i (state.repeat_count_select),
    .left_justify_select_i (state.left_justify_select), // RULE9
    .res                   (res_bus.dst),
    .done_o                (fmt_done),
    .result_high_o         (fmt_high),
    .result_low_o          (fmt_low)
  );

  always_comb begin
    next_state       = state;
    next_state.done  = fmt_done;
    next_state.hit   = 1'b0;
    next_state.rdata = 8'h00;
    if (fmt_done) begin
      next_state.result_high = fmt_high; // RULE12
      next_state.result_low  = fmt_low; // RULE12
    end
    if (reg_wr_i) begin
      case (reg_addr_i)
        AGF_ADDR_GAIN_HIGH:   next_state.gain_high = reg_wdata_i;
        AGF_ADDR_GAIN_LOW:    next_state.gain_low = {reg_wdata_i[7:4], 4'h0};
        AGF_ADDR_GAIN_ADD:    next_state.gain_offset_add = reg_wdata_i[AGF_GAIN_ADD_BIT];
        AGF_ADDR_FORMAT: begin
          next_state.left_justify_select = reg_wdata_i[AGF_LJST_BIT];
          next_state.repeat_count_select = reg_wdata_i[AGF_RPT_LSB +: 2];
        end
        AGF_ADDR_RESULT_HIGH: if (!fmt_done) next_state.result_high = reg_wdata_i;
        AGF_ADDR_RESULT_LOW:  if (!fmt_done) next_state.result_low = reg_wdata_i;
        default: ;
      endcase
    end
    if (reg_rd_i) begin
      next_state.hit = 1'b1;
      case (reg_addr_i)
        AGF_ADDR_GAIN_HIGH:   next_state.rdata = state.gain_high;
        AGF_ADDR_GAIN_LOW:    next_state.rdata = state.gain_low;
        AGF_ADDR_GAIN_ADD:    next_state.rdata = {7'h00, state.gain_offset_add};
        AGF_ADDR_FORMAT:      next_state.rdata = {5'h00, state.left_justify_select, state.repeat_count_select};
        AGF_ADDR_RESULT_HIGH: next_state.rdata = state.result_high;
        AGF_ADDR_RESULT_LOW:  next_state.rdata = state.result_low;
        default:              next_state.hit = 1'b0;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      state                     <= '0;
      state.gain_high           <= AGF_RST_GAIN_HIGH; // RULE3
      state.gain_low            <= AGF_RST_GAIN_LOW; // RULE3
      state.gain_offset_add     <= AGF_RST_GAIN_ADD; // RULE3
      state.result_high         <= AGF_RST_RESULT;
      state.result_low          <= AGF_RST_RESULT;
    end else begin
      state <= next_state;
    end
  end

  assign reg_rdata_o = state.rdata;
  assign reg_hit_o   = state.hit;
  assign conv_done_o = state.done;

  reset_gain_a: assert property (@(posedge ref_clk_i)
    $rose(rst_n_i) |-> (state.gain_high == 8'hFC && state.gain_low == 8'h00 && state.gain_offset_add))
    else $error("gain reset values wrong"); // RULE3
  gain_word_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (reg_wr_i && reg_addr_i == AGF_ADDR_GAIN_LOW) |=> gain_word[3:0] == $past(reg_wdata_i[7:4]))
    else $error("gain low nibble not taken"); // RULE1
  result_load_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    fmt_done |=> (state.result_high == $past(fmt_high) && state.result_low == $past(fmt_low)))
    else $error("result bytes not loaded together"); // RULE12
  left_high_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (raw_valid_i && state.left_justify_select && state.repeat_count_select == 2'b00
     && gain_word == 12'hFC0 && state.gain_offset_add && !reg_wr_i)
    |-> ##3 state.result_high == $past(raw_sample_i[11:4], 3))
    else $error("left justified high byte wrong"); // RULE8

endmodule : agf_top
